// ---- ncr_pkg.sv ----
// Package for the namespace capability report block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ncr_pkg;
  // Register byte offsets (printed offsets are bytes 30, 31, 32 of the identify data)
  localparam logic [7:0] NCR_IDX_SHARING = 8'h1e;
  localparam logic [7:0] NCR_IDX_RESV = 8'h1f;
  localparam logic [7:0] NCR_IDX_PROGRESS = 8'h20;
  // Report byte registers and own control registers, as byte addresses
  localparam logic [9:0] NCR_ADDR_SHARING = 10'h078;
  localparam logic [9:0] NCR_ADDR_RESV = 10'h07c;
  localparam logic [9:0] NCR_ADDR_PROGRESS = 10'h080;
  localparam logic [9:0] NCR_ADDR_CONFIG = 10'h100;
  localparam logic [9:0] NCR_ADDR_FMT_CTRL = 10'h104;
  localparam logic [9:0] NCR_ADDR_PROT = 10'h108;
  // Config register fields
  localparam int NCR_CFG_SHARED_BIT = 0;
  localparam int NCR_CFG_PTPL_BIT = 1;
  localparam int NCR_CFG_TYPES_LSB = 2;
  localparam int NCR_CFG_PROG_SUP_BIT = 8;
  localparam int NCR_CFG_VER_MINOR_LSB = 16;
  localparam int NCR_CFG_VER_MAJOR_LSB = 24;
  // Format control fields
  localparam int NCR_FMT_START_BIT = 0;
  localparam int NCR_FMT_STEP_BIT = 1;
  // Capability byte fields
  localparam int NCR_RES_IEK_BIT = 7;
  localparam int NCR_PROG_SUP_POS = 7;
  localparam int NCR_PROT_W = 3;
  // Reset value, format start value and protection setting limit
  localparam logic [31:0] NCR_CONFIG_RST = 32'h0001_0000;
  localparam logic [6:0] NCR_PCT_FULL = 7'h64;
  localparam logic [2:0] NCR_PROT_MAX = 3'h3;
  // Version threshold for the newer key semantics
  localparam logic [7:0] NCR_VER_MAJOR_MIN = 8'h01;
  localparam logic [7:0] NCR_VER_MINOR_MIN = 8'h03;
  localparam logic [1:0] NCR_HTRANS_NONSEQ = 2'h2;
  typedef enum logic {NCR_FMT_IDLE, NCR_FMT_BUSY} ncr_fmt_t;
endpackage

// ---- ncr_progress.sv ----
// Format progress counter: remaining percentage during a format.
// Assumes start and step are one-cycle pulses from the same clock.
module ncr_progress
  import ncr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic step_in,
  output logic busy_out,
  output logic [6:0] remain_out
);
  ncr_fmt_t state;
  logic [6:0] remain;
  wire last_step = step_in && (remain == 7'h01);

  // Remaining count only falls, starts at 100
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state <= NCR_FMT_IDLE;
      remain <= 7'h00;
    end else begin
      unique case (state)
        NCR_FMT_IDLE: begin
          if (start_in) begin
            state <= NCR_FMT_BUSY;
            remain <= NCR_PCT_FULL; // [R11]
          end
        end
        NCR_FMT_BUSY: begin
          if (last_step) begin
            state <= NCR_FMT_IDLE;
            remain <= 7'h00; // [R9]
          end else if (step_in) begin
            remain <= remain - 7'h01; // [R8] [R11]
          end
        end
      endcase
    end
  end

  assign busy_out = (state == NCR_FMT_BUSY);
  assign remain_out = remain;
endmodule // ncr_progress

// ---- ncr_top.sv ----
// Namespace capability report register bank on AHB-Lite.
// Assumes a single master, single word transfers, one clock at 10 MHz.
// Overview of operation
// R1: Sharing byte bit 0 is 1 for a shared namespace and 0 for a private one.
// R2: Sharing byte bits 7:1 are reserved and read as zero.
// R3: The reservation byte reads all zero when reservations are unsupported.
// R4: Reservation bit 7 is 1 when reservations are supported and the version is 1.3 or later.
// R5: Reservation bits 1 to 6 flag the six supported reservation types.
// R6: Reservation bit 0 is 1 only when state persists through power loss.
// R7: Progress bit 7 flags support; without it bits 6:0 read zero.
// R8: During a format, progress bits 6:0 give the percentage remaining.
// R9: With support and no format pending, the remaining value is zero.
// R10: Protection settings sit in the low three bits, 000b off, 001b-011b types 1-3.
// R11: The remaining value never exceeds 100 and only falls during one format.
//
// Design decision made here: register access over AHB-Lite.
module ncr_top
  import ncr_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic FORMAT_BUSY_OUT
);
  logic [31:0] config_reg;
  logic [2:0] prot_settings;
  logic wr_pending;
  logic [9:0] wr_addr;
  logic fmt_start;
  logic fmt_step;
  logic busy;
  logic [6:0] remain;
  logic [31:0] rdata;
  logic busy_q;

  // Address phase decode
  wire addr_phase = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire [9:0] a_addr = HADDR_IN[9:0];
  wire [9:0] rd_addr = a_addr;

  // Config fields
  wire shared_ns = config_reg[NCR_CFG_SHARED_BIT];
  wire ptpl = config_reg[NCR_CFG_PTPL_BIT];
  wire [5:0] res_types = config_reg[NCR_CFG_TYPES_LSB +: 6];
  wire prog_sup = config_reg[NCR_CFG_PROG_SUP_BIT];
  wire [7:0] ver_major = config_reg[NCR_CFG_VER_MAJOR_LSB +: 8];
  wire [7:0] ver_minor = config_reg[NCR_CFG_VER_MINOR_LSB +: 8];

  // Version 1.3 or later selects newer key semantics
  wire ver_new = (ver_major > NCR_VER_MAJOR_MIN) ||
                 ((ver_major == NCR_VER_MAJOR_MIN) && (ver_minor >= NCR_VER_MINOR_MIN));
  wire res_any = ptpl || (res_types != 6'h00);
  // Sharing byte, reserved bits zero
  wire [7:0] sharing_byte = {7'h00, shared_ns}; // [R1] [R2]
  // Reservation byte, zero when nothing supported
  wire [7:0] resv_byte = res_any ?
      {ver_new, res_types, ptpl} : 8'h00; // [R3] [R4] [R5] [R6]
  // Progress byte, low bits forced clear without support
  wire [7:0] progress_byte = prog_sup ?
      {1'b1, remain} : 8'h00; // [R7] [R8] [R9]

  // Write data phase decode
  wire wr_config = wr_pending && (wr_addr == NCR_ADDR_CONFIG);
  wire wr_fmt = wr_pending && (wr_addr == NCR_ADDR_FMT_CTRL);
  wire wr_prot = wr_pending && (wr_addr == NCR_ADDR_PROT);
  wire prot_legal = HWDATA_IN[NCR_PROT_W-1:0] <= NCR_PROT_MAX;
  wire next_fmt_start = wr_fmt && HWDATA_IN[NCR_FMT_START_BIT];
  wire next_fmt_step = wr_fmt && HWDATA_IN[NCR_FMT_STEP_BIT];

  // Read mux
  wire [31:0] next_rdata =
      (rd_addr == NCR_ADDR_SHARING) ? {24'h000000, sharing_byte} :
      (rd_addr == NCR_ADDR_RESV) ? {24'h000000, resv_byte} :
      (rd_addr == NCR_ADDR_PROGRESS) ? {24'h000000, progress_byte} :
      (rd_addr == NCR_ADDR_CONFIG) ? config_reg :
      (rd_addr == NCR_ADDR_PROT) ? {29'h00000000, prot_settings} :
      32'h00000000;

  // Bus pipeline state
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      wr_pending <= 1'b0;
      wr_addr <= 10'h000;
      rdata <= 32'h00000000;
    end else begin
      wr_pending <= addr_phase && HWRITE_IN;
      if (addr_phase) begin
        wr_addr <= a_addr;
      end
      if (addr_phase && !HWRITE_IN) begin
        rdata <= next_rdata;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      config_reg <= NCR_CONFIG_RST;
      prot_settings <= 3'h0;
      fmt_start <= 1'b0;
      fmt_step <= 1'b0;
    end else begin
      if (wr_config) begin
        config_reg <= HWDATA_IN;
      end
      if (wr_prot && prot_legal) begin
        prot_settings <= HWDATA_IN[NCR_PROT_W-1:0]; // [R10]
      end
      fmt_start <= next_fmt_start;
      fmt_step <= next_fmt_step;
    end
  end

  // Busy flag registered for the output pin
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end

  ncr_progress u_progress (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .start_in(fmt_start),
    .step_in(fmt_step),
    .busy_out(busy),
    .remain_out(remain)
  );

  assign HRDATA_OUT = rdata;
  assign HREADYOUT_OUT = 1'b1; // Zero wait states
  assign HRESP_OUT = 1'b0; // Always OKAY
  assign FORMAT_BUSY_OUT = busy_q;
endmodule // ncr_top

// ---- ncr_checker.sv ----
// Checker for the capability bank, watching top ports only.
// Assumes one AHB-Lite master and config written as whole words.
module ncr_checker
  import ncr_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_cfg;
  logic [2:0] rd;
  logic [31:0] cfg;
  // Taken transfer decode
  wire take = RST_B_IN && HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire [9:0] a = HADDR_IN[9:0];
  wire [7:0] b = HRDATA_OUT[7:0];
  wire [2:0] hit = {a == NCR_ADDR_PROGRESS, a == NCR_ADDR_RESV, a == NCR_ADDR_SHARING};
  wire typ = cfg[7:2] != 6'h00;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Read flags and a shadow of the config word
  always_ff @(posedge REF_CLK_IN) begin
    wr_cfg <= take && HWRITE_IN && a == NCR_ADDR_CONFIG;
    rd <= take && !HWRITE_IN ? hit : 3'h0;
    cfg <= !RST_B_IN ? NCR_CONFIG_RST : wr_cfg ? HWDATA_IN : cfg;
  end
  share_bit_a: assert property (rd[0] |-> b[0] == cfg[0])
    else $error("sharing bit wrong");
  share_rsvd_a: assert property (rd[0] |-> b[7:1] == 7'h00)
    else $error("sharing reserved bits set");
  res_none_a: assert property (rd[1] && cfg[7:1] == 7'h00 |-> b == 8'h00)
    else $error("reservation byte not zero");
  res_key_a: assert property (rd[1] && typ && cfg[31:16] >= 16'h0103 |-> b[7])
    else $error("key semantics bit clear");
  res_types_a: assert property (rd[1] && typ |-> b[6:1] == cfg[7:2])
    else $error("reservation types wrong");
  res_ptpl_a: assert property (rd[1] && typ |-> b[0] == cfg[1])
    else $error("power loss bit wrong");
  prog_off_a: assert property (rd[2] |-> b[7] == cfg[8] && (b[7] || b[6:0] == 7'h00))
    else $error("progress support wrong");
  prog_cap_a: assert property (rd[2] |-> b[6:0] <= 7'h64)
    else $error("progress above hundred");
endmodule // ncr_checker
bind ncr_top ncr_checker i_ncr_checker (.REF_CLK_IN, .RST_B_IN, .HSEL_IN, .HADDR_IN,
  .HTRANS_IN, .HWRITE_IN, .HWDATA_IN, .HREADY_IN, .HRDATA_OUT);

// ---- ncr_host.sv ----
// Host model: AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
module ncr_host
  import ncr_pkg::*;
(
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [31:0] hwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hwdata_out = 32'h0;
  end
  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    haddr_out <= {22'h0, a};
    htrans_out <= NCR_HTRANS_NONSEQ;
    hwrite_out <= w;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
  endtask
endmodule // ncr_host

// ---- namespace_capability_report_test.sv ----
// Testbench for the capability bank: random configs and a full format.
// Assumes the host model drives the bus and the checker is bound.
module namespace_capability_report_test
  import ncr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic busy, hready, hresp, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q, c;
  int miscompares = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  ncr_top i_ncr_top (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .FORMAT_BUSY_OUT(busy));
  ncr_host i_ncr_host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata));
  // Compare, bus helpers, verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [9:0] a, input logic [31:0] d);
    i_ncr_host.xfer(1'b1, a, d, q);
  endtask
  task automatic get(input logic [9:0] a, input logic [31:0] exp);
    i_ncr_host.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] exp_res(input logic [31:0] v);
    exp_res = v[7:1] == 7'h00 ? 32'h0 : {24'h0, v[31:16] >= 16'h0103, v[7:1]};
  endfunction
  // Main sequence
  initial begin
    c = $urandom(32'h426c1372);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      c = $urandom;
      if (i < 3) c[31:16] = 16'h0103 - 16'(i);
      if (c[7:2] == 6'h00 || i == 3) c[7:1] = 7'h00;
      put(NCR_ADDR_CONFIG, c);
      get(NCR_ADDR_SHARING, {31'h0, c[0]});
      get(NCR_ADDR_RESV, exp_res(c));
      get(NCR_ADDR_PROGRESS, {24'h0, c[8], 7'h00});
    end
    get(10'h084, 32'h0);
    for (int p = 0; p < 5; p++) begin
      put(NCR_ADDR_PROT, p == 4 ? 32'h7 : 32'(p));
      get(NCR_ADDR_PROT, p == 4 ? 32'h3 : 32'(p));
    end
    put(NCR_ADDR_CONFIG, 32'h0103_0100);
    for (int k = 0; k <= 100; k++) begin
      if (k == 50) put(NCR_ADDR_FMT_CTRL, 32'h1);
      put(NCR_ADDR_FMT_CTRL, k == 0 ? 32'h1 : 32'h2);
      repeat (2) @(posedge clk);
      get(NCR_ADDR_PROGRESS, 32'h80 | 32'(100 - k));
      check({31'h0, busy}, {31'h0, k < 100});
    end
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule // namespace_capability_report_test
